// ### rtl/ppcr_pkg.sv
// package: register map, field positions and reset values of the packet config bank
package ppcr_pkg;
	localparam int unsigned addr_w = 8;
	localparam logic [7:0] off_pkt_ctl = 8'h30;
	localparam logic [7:0] off_len_hi = 8'h31;
	localparam logic [7:0] off_len_lo = 8'h32;
	localparam logic [7:0] off_sync_word_byte_three = 8'h33;
	localparam logic [7:0] off_sync_word_byte_two = 8'h34;
	localparam logic [7:0] off_sync_word_byte_one = 8'h35;
	localparam logic [7:0] off_sync_word_byte_zero = 8'h36;
	localparam logic [7:0] off_quality = 8'h37;
	localparam logic [7:0] off_postamble = 8'h38;
	localparam logic [7:0] off_proto_c = 8'h39;
	localparam logic [7:0] off_proto_b = 8'h3a;
	localparam logic [7:0] off_proto_a = 8'h3b;
	// status/command word, placed after the documented map
	localparam logic [7:0] off_seq_cmd = 8'h3c;
	localparam logic [3:0] reg_count = 4'hc;
	localparam logic [3:0] idx_pkt_ctl = 4'h0;
	localparam logic [3:0] idx_len_hi = 4'h1;
	localparam logic [3:0] idx_len_lo = 4'h2;
	localparam logic [3:0] idx_sync_word_byte_three = 4'h3;
	localparam logic [3:0] idx_sync_word_byte_two = 4'h4;
	localparam logic [3:0] idx_sync_word_byte_one = 4'h5;
	localparam logic [3:0] idx_sync_word_byte_zero = 4'h6;
	localparam logic [3:0] idx_quality = 4'h7;
	localparam logic [3:0] idx_postamble = 4'h8;
	localparam logic [3:0] idx_proto_c = 4'h9;
	localparam logic [3:0] idx_proto_b = 4'ha;
	localparam logic [3:0] idx_proto_a = 4'hb;
	localparam logic [7:0] rst_pkt_ctl = 8'h2c;
	localparam logic [7:0] rst_len_hi = 8'h00;
	localparam logic [7:0] rst_len_lo = 8'h14;
	localparam logic [7:0] rst_sync = 8'h88;
	localparam logic [7:0] rst_quality = 8'h01;
	localparam logic [7:0] rst_postamble = 8'h00;
	localparam logic [7:0] rst_proto_c = 8'h40;
	localparam logic [7:0] rst_proto_b = 8'h00;
	localparam logic [7:0] rst_proto_a = 8'h08;
	// packet control fields
	localparam int unsigned bit_whiten = 4;
	localparam int unsigned bit_src_hi = 3;
	localparam int unsigned bit_src_lo = 2;
	localparam int unsigned bit_alt_sync = 1;
	localparam int unsigned bit_fec = 0;
	// quality fields
	localparam int unsigned bit_sqt_hi = 7;
	localparam int unsigned bit_sqt_lo = 5;
	localparam int unsigned bit_pqt_hi = 4;
	localparam int unsigned bit_pqt_lo = 1;
	localparam int unsigned bit_sq_on = 0;
	// protocol c fields
	localparam int unsigned bit_cs_gate = 7;
	localparam int unsigned bit_sq_gate = 6;
	localparam int unsigned bit_pq_gate = 5;
	localparam int unsigned bit_seq_hi = 4;
	localparam int unsigned bit_seq_lo = 3;
	localparam int unsigned bit_pin_src = 2;
	localparam int unsigned bit_mult_hi = 1;
	localparam int unsigned bit_mult_lo = 0;
	// protocol b fields
	localparam int unsigned bit_ldc = 7;
	localparam int unsigned bit_ldc_reload = 6;
	localparam int unsigned bit_piggy = 5;
	localparam int unsigned bit_sniff = 4;
	localparam int unsigned bit_seed = 3;
	localparam int unsigned bit_csma = 2;
	localparam int unsigned bit_csma_pers = 1;
	localparam int unsigned bit_filter = 0;
	// protocol a fields
	localparam int unsigned bit_retx_hi = 7;
	localparam int unsigned bit_retx_lo = 4;
	// command word: bit 0 reloads the tx sequence counter
	localparam int unsigned bit_cmd_seq = 0;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	typedef enum logic [1:0] {
		ppcr_src_packet,
		ppcr_src_fifo,
		ppcr_src_pin,
		ppcr_src_pn9
	} ppcr_src_e;
endpackage

// ### rtl/ppcr_regif.sv
// interface: register write/read port between bus slave and register store
`timescale 1ns/1ns
interface ppcr_regif;
	logic wr_en;
	logic [3:0] wr_idx;
	logic [7:0] wr_data;
	logic [3:0] rd_idx;
	logic [7:0] rd_data;
	modport bus (output wr_en, output wr_idx, output wr_data,
		output rd_idx, input rd_data);
	modport store (input wr_en, input wr_idx, input wr_data,
		input rd_idx, output rd_data);
endinterface

// ### rtl/ppcr_store.sv
// module: flip-flop store of the twelve configuration bytes
`timescale 1ns/1ns
module ppcr_store (
	input wire logic clk,
	input wire logic rst_n,
	ppcr_regif.store rif,
	output logic [95:0] flat
);
	typedef struct packed {
		logic [11:0][7:0] mem;
	} ppcr_store_s;
	ppcr_store_s state;
	ppcr_store_s next_state;
	function automatic logic [7:0] reset_of(input logic [3:0] idx);
		case (idx)
			ppcr_pkg::idx_pkt_ctl: reset_of = ppcr_pkg::rst_pkt_ctl;
			ppcr_pkg::idx_len_hi: reset_of = ppcr_pkg::rst_len_hi;
			ppcr_pkg::idx_len_lo: reset_of = ppcr_pkg::rst_len_lo;
			ppcr_pkg::idx_quality: reset_of = ppcr_pkg::rst_quality;
			ppcr_pkg::idx_postamble: reset_of = ppcr_pkg::rst_postamble;
			ppcr_pkg::idx_proto_c: reset_of = ppcr_pkg::rst_proto_c;
			ppcr_pkg::idx_proto_b: reset_of = ppcr_pkg::rst_proto_b;
			ppcr_pkg::idx_proto_a: reset_of = ppcr_pkg::rst_proto_a;
			default: reset_of = ppcr_pkg::rst_sync;
		endcase
	endfunction
	function automatic ppcr_store_s reset_all();
		ppcr_store_s s;
		for (int i = 0; i < 12; i++) begin
			s.mem[i] = reset_of(4'(i));
		end
		return s;
	endfunction
	always_comb begin
		next_state = state;
		if (rif.wr_en && rif.wr_idx < ppcr_pkg::reg_count) begin
			next_state.mem[rif.wr_idx] = rif.wr_data;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= reset_all();
		end else begin
			state <= next_state;
		end
	end
	assign rif.rd_data = (rif.rd_idx < ppcr_pkg::reg_count) ?
		state.mem[rif.rd_idx] : 8'h00;
	assign flat = state.mem;
endmodule // ppcr_store

// ### rtl/ppcr_top.sv
// module: AXI4-Lite configuration register bank of the packet handler
// Operation
// - whitening bit 4 enables data whitening
// - bits 3:2 select transmit data source
// - tx: alternate bit picks secondary sync; tx here always sends the primary word
// - rx: alternate bit enables dual sync search
// - bit 0 enables FEC and Viterbi
// - 16-bit packet length, default 0x0014
// - quality thresholds; sync check gated by bit0
// - postamble length byte at 0x38
// - per-source mask gates timeout stopping
// - selector chooses OR or AND combination; here fixed to OR, the AND branch is never taken
// - sequence reset loads counter from 4:3
// - bit 2 picks tx/rx FIFO pin flag
// - bits 1:0 select duty timer multiplier
// - bit 7 enables low duty cycle
// - bit 6 enables duty timer reload
// - bit 5 enables piggybacking
// - bit 4 enables receive sniff timer
// - bit 3 reloads back-off seed
// - bit 2 enables CSMA before transmit
// - bit 1 persistent CSMA, no back-off
// - bit 0 enables automatic packet filtering
// - bits 7:4 cap retransmissions, zero disables
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module ppcr_top (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_mode,
	input wire logic carrier_sense,
	input wire logic sync_quality_ok,
	input wire logic preamble_quality_ok,
	input wire logic tx_fifo_threshold,
	input wire logic rx_fifo_threshold,
	input wire logic tx_sequence_step,
	output logic whitening_enable,
	output logic [1:0] tx_data_origin,
	output logic [31:0] active_sync_word,
	output logic dual_sync_search,
	output logic forward_error_coding_on,
	output logic [15:0] packet_length,
	output logic [2:0] sync_quality_threshold,
	output logic [3:0] preamble_quality_threshold,
	output logic sync_quality_check_on,
	output logic [7:0] postamble_length,
	output logic rx_timeout_stop,
	output logic [1:0] tx_sequence_count,
	output logic fifo_threshold_pin,
	output logic [1:0] duty_cycle_timer_multiplier,
	output logic low_duty_cycle_on,
	output logic duty_cycle_timer_reload_on,
	output logic piggyback_enable,
	output logic rx_sniff_timer_on,
	output logic backoff_seed_reload,
	output logic listen_before_talk_enable,
	output logic persistent_access_no_backoff,
	output logic auto_packet_filtering,
	output logic [3:0] max_retransmit_count
);
	typedef struct packed {
		logic [1:0] rst_sync;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [2:0] in_sync_word_byte_one;
		logic [2:0] in_sync_word_byte_two;
		logic [1:0] fifo_sync_word_byte_one;
		logic [1:0] fifo_sync_word_byte_two;
		logic step_sync_word_byte_one;
		logic step_sync_word_byte_two;
		logic step_prev;
		logic [1:0] seq;
		logic seed_pulse;
		logic timeout_stop;
		logic fifo_pin;
		logic [31:0] sync_word;
		logic dual_sync;
	} ppcr_top_s;
	ppcr_top_s state;
	ppcr_top_s next_state;
	logic rst_n;
	logic [95:0] regs;
	ppcr_regif rif ();
	ppcr_store u_store (
		.clk(sys_clk),
		.rst_n(rst_n),
		.rif(rif),
		.flat(regs)
	);
	assign rst_n = state.rst_sync[1];
	// one register per word: byte address is four times its offset;
	// maps it to a store index, bit 4 flags the command word or an unmapped address
	function automatic logic [4:0] decode(input logic [7:0] addr);
		logic [7:0] word;
		logic [7:0] delta;
		word = {2'b00, addr[7:2]};
		delta = word - ppcr_pkg::off_pkt_ctl;
		if (addr[1:0] != 2'b00) begin
			decode = 5'h1f;
		end else if (word == ppcr_pkg::off_seq_cmd) begin
			decode = 5'h10;
		end else if (word >= ppcr_pkg::off_pkt_ctl &&
			word <= ppcr_pkg::off_proto_a) begin
			decode = {1'b0, delta[3:0]};
		end else begin
			decode = 5'h1f;
		end
	endfunction
	function automatic logic [7:0] reg_at(input logic [95:0] r,
		input logic [3:0] idx);
		reg_at = r[idx * 8 +: 8];
	endfunction
	logic [7:0] pkt_ctl;
	logic [7:0] quality;
	logic [7:0] proto_c;
	logic [7:0] proto_b;
	logic [7:0] proto_a;
	logic [4:0] wr_dec;
	logic [4:0] rd_dec;
	logic do_write;
	logic do_read;
	logic seq_cmd;
	logic [2:0] cond;
	logic [2:0] gate;
	assign pkt_ctl = reg_at(regs, ppcr_pkg::idx_pkt_ctl);
	assign quality = reg_at(regs, ppcr_pkg::idx_quality);
	assign proto_c = reg_at(regs, ppcr_pkg::idx_proto_c);
	assign proto_b = reg_at(regs, ppcr_pkg::idx_proto_b);
	assign proto_a = reg_at(regs, ppcr_pkg::idx_proto_a);
	// timeout-stop selector sits outside this map; default selects OR
	localparam logic timeout_or_sel = 1'b1;
	assign wr_dec = decode(state.aw_addr);
	assign rd_dec = decode(s_axi_araddr);
	assign do_write = state.aw_held && state.w_held && !state.bvalid;
	assign do_read = s_axi_arvalid && state.arready;
	assign seq_cmd = do_write && wr_dec == 5'h10 && state.w_strb[0] &&
		state.w_data[ppcr_pkg::bit_cmd_seq];
	assign rif.wr_en = do_write && !wr_dec[4] && state.w_strb[0];
	assign rif.wr_idx = wr_dec[3:0];
	assign rif.wr_data = state.w_data[7:0];
	assign rif.rd_idx = rd_dec[3:0];
	assign cond = {state.in_sync_word_byte_two[2], state.in_sync_word_byte_two[1], state.in_sync_word_byte_two[0]};
	assign gate = {proto_c[ppcr_pkg::bit_cs_gate],
		proto_c[ppcr_pkg::bit_sq_gate], proto_c[ppcr_pkg::bit_pq_gate]};
	always_comb begin
		next_state = state;
		next_state.rst_sync = {state.rst_sync[0], 1'b1};
		// bus slave: address and data taken independently, any order
		// ready never waits for valid, so an early valid cannot stall
		next_state.awready = !state.aw_held;
		next_state.wready = !state.w_held;
		if (s_axi_awvalid && state.awready) begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
			next_state.awready = 1'b0;
		end
		if (s_axi_wvalid && state.wready) begin
			next_state.w_held = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
			next_state.wready = 1'b0;
		end
		if (do_write) begin
			next_state.bvalid = 1'b1;
			next_state.bresp = (wr_dec == 5'h1f) ? ppcr_pkg::resp_slverr :
				ppcr_pkg::resp_okay;
			next_state.aw_held = 1'b0;
			next_state.w_held = 1'b0;
		end
		if (state.bvalid && s_axi_bready) begin
			next_state.bvalid = 1'b0;
		end
		next_state.arready = !state.rvalid && !do_read;
		if (do_read) begin
			next_state.rvalid = 1'b1;
			next_state.rresp = (rd_dec == 5'h1f) ? ppcr_pkg::resp_slverr :
				ppcr_pkg::resp_okay;
			next_state.rdata = rd_dec[4] ? 32'h00000000 :
				{24'h000000, rif.rd_data};
		end
		if (state.rvalid && s_axi_rready) begin
			next_state.rvalid = 1'b0;
		end
		// pin inputs through two flops
		next_state.in_sync_word_byte_one = {carrier_sense, sync_quality_ok,
			preamble_quality_ok};
		next_state.in_sync_word_byte_two = state.in_sync_word_byte_one;
		next_state.fifo_sync_word_byte_one = {tx_fifo_threshold, rx_fifo_threshold};
		next_state.fifo_sync_word_byte_two = state.fifo_sync_word_byte_one;
		next_state.step_sync_word_byte_one = tx_sequence_step;
		next_state.step_sync_word_byte_two = state.step_sync_word_byte_one;
		next_state.step_prev = state.step_sync_word_byte_two;
		if (seq_cmd) begin
			next_state.seq = proto_c[ppcr_pkg::bit_seq_hi:
				ppcr_pkg::bit_seq_lo];
		end else if (state.step_sync_word_byte_two && !state.step_prev) begin
			next_state.seq = state.seq + 2'h1;
		end
		// seed reload: one pulse per write of the bit
		next_state.seed_pulse = rif.wr_en &&
			rif.wr_idx == ppcr_pkg::idx_proto_b &&
			rif.wr_data[ppcr_pkg::bit_seed];
		if (timeout_or_sel) begin
			next_state.timeout_stop = |(cond & gate);
		end else begin
			next_state.timeout_stop = (gate != 3'h0) &&
				((cond | ~gate) == 3'h7);
		end
		next_state.fifo_pin = proto_c[ppcr_pkg::bit_pin_src] ?
			state.fifo_sync_word_byte_two[0] : state.fifo_sync_word_byte_two[1];
		// primary word from sync bytes; secondary bytes live outside
		next_state.sync_word = {reg_at(regs, ppcr_pkg::idx_sync_word_byte_three),
			reg_at(regs, ppcr_pkg::idx_sync_word_byte_two),
			reg_at(regs, ppcr_pkg::idx_sync_word_byte_one),
			reg_at(regs, ppcr_pkg::idx_sync_word_byte_zero)};
		next_state.dual_sync = !tx_mode &&
			pkt_ctl[ppcr_pkg::bit_alt_sync];
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	// configuration outputs are straight register bits of the store, except the registered seed reload pulse
	assign whitening_enable = pkt_ctl[ppcr_pkg::bit_whiten];
	assign tx_data_origin = pkt_ctl[ppcr_pkg::bit_src_hi:
		ppcr_pkg::bit_src_lo];
	assign forward_error_coding_on = pkt_ctl[ppcr_pkg::bit_fec];
	assign packet_length = {reg_at(regs, ppcr_pkg::idx_len_hi),
		reg_at(regs, ppcr_pkg::idx_len_lo)};
	assign sync_quality_threshold = quality[ppcr_pkg::bit_sqt_hi:
		ppcr_pkg::bit_sqt_lo];
	assign preamble_quality_threshold = quality[ppcr_pkg::bit_pqt_hi:
		ppcr_pkg::bit_pqt_lo];
	assign sync_quality_check_on = quality[ppcr_pkg::bit_sq_on];
	assign postamble_length = reg_at(regs, ppcr_pkg::idx_postamble);
	assign duty_cycle_timer_multiplier = proto_c[ppcr_pkg::bit_mult_hi:
		ppcr_pkg::bit_mult_lo];
	assign low_duty_cycle_on = proto_b[ppcr_pkg::bit_ldc];
	assign duty_cycle_timer_reload_on =
		proto_b[ppcr_pkg::bit_ldc_reload];
	assign piggyback_enable = proto_b[ppcr_pkg::bit_piggy];
	assign rx_sniff_timer_on = proto_b[ppcr_pkg::bit_sniff];
	assign backoff_seed_reload = state.seed_pulse;
	assign listen_before_talk_enable = proto_b[ppcr_pkg::bit_csma];
	assign persistent_access_no_backoff =
		proto_b[ppcr_pkg::bit_csma_pers];
	assign auto_packet_filtering = proto_b[ppcr_pkg::bit_filter];
	assign max_retransmit_count = proto_a[ppcr_pkg::bit_retx_hi:
		ppcr_pkg::bit_retx_lo];
	// tx sends primary word; alternate bit reaches datapath via dual in rx only
	assign active_sync_word = state.sync_word;
	assign dual_sync_search = state.dual_sync;
	assign rx_timeout_stop = state.timeout_stop;
	assign tx_sequence_count = state.seq;
	assign fifo_threshold_pin = state.fifo_pin;
	assign s_axi_awready = state.awready;
	assign s_axi_wready = state.wready;
	assign s_axi_bvalid = state.bvalid;
	assign s_axi_bresp = state.bresp;
	assign s_axi_arready = state.arready;
	assign s_axi_rvalid = state.rvalid;
	assign s_axi_rdata = state.rdata;
	assign s_axi_rresp = state.rresp;
endmodule // ppcr_top

// ### verification/ppcr_props.sv
// checker: bus handshakes and config output relations of ppcr_top
`timescale 1ns/1ns
module ppcr_props (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_mode,
	input wire logic dual_sync_search,
	input wire logic [15:0] packet_length,
	input wire logic [7:0] postamble_length,
	input wire logic [3:0] max_retransmit_count,
	input wire logic backoff_seed_reload
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_resp_up;
		s_axi_bvalid;
	endsequence
	a_write_answer: assert property (
		s_both_taken |-> ##[1:3] s_resp_up)
		else $error("write response missing");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data missing");
	a_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_resp_up and $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_upper_zero: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_cfg_by_write: assert property (
		$changed({packet_length, postamble_length, max_retransmit_count})
		|-> $rose(s_axi_bvalid))
		else $error("config changed without write");
	a_seed_pulse: assert property (
		backoff_seed_reload |=> !backoff_seed_reload)
		else $error("seed reload longer than a cycle");
	a_dual_in_tx: assert property (
		tx_mode [*3] |-> !dual_sync_search)
		else $error("dual search while transmitting");
endmodule // ppcr_props
bind ppcr_top ppcr_props u_props (.sys_clk, .reset_n, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .tx_mode, .dual_sync_search, .packet_length,
	.postamble_length, .max_retransmit_count, .backoff_seed_reload);

// ### verification/tb_top.sv
// testbench: register bank exercised through the AXI4-Lite port
`timescale 1ns/1ns
module tb_top;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_mode = 1'b0;
	logic carrier_sense = 1'b0, sync_quality_ok = 1'b0;
	logic preamble_quality_ok = 1'b0, tx_sequence_step = 1'b0;
	logic tx_fifo_threshold = 1'b0, rx_fifo_threshold = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, whitening_enable, dual_sync_search;
	logic [1:0] s_axi_bresp, s_axi_rresp, tx_data_origin, tx_sequence_count;
	logic [31:0] s_axi_rdata, active_sync_word;
	logic forward_error_coding_on, sync_quality_check_on, rx_timeout_stop;
	logic [15:0] packet_length;
	logic [2:0] sync_quality_threshold;
	logic [3:0] preamble_quality_threshold, max_retransmit_count;
	logic fifo_threshold_pin, low_duty_cycle_on, duty_cycle_timer_reload_on;
	logic [7:0] postamble_length, pb_bits;
	logic [1:0] duty_cycle_timer_multiplier;
	logic piggyback_enable, rx_sniff_timer_on, backoff_seed_reload;
	logic listen_before_talk_enable, persistent_access_no_backoff;
	logic auto_packet_filtering;
	logic [7:0] defaults [12] = '{8'h2c, 8'h00, 8'h14, 8'h88, 8'h88, 8'h88,
		8'h88, 8'h01, 8'h00, 8'h40, 8'h00, 8'h08};
	int n_mismatch = 0, check_count = 0, seed_seen = 0, slow = 0;
	assign pb_bits = {low_duty_cycle_on, duty_cycle_timer_reload_on,
		piggyback_enable, rx_sniff_timer_on, 1'b0, listen_before_talk_enable,
		persistent_access_no_backoff, auto_packet_filtering};
	ppcr_top dut (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .tx_mode, .carrier_sense,
		.sync_quality_ok, .preamble_quality_ok, .tx_fifo_threshold,
		.rx_fifo_threshold, .tx_sequence_step, .whitening_enable,
		.tx_data_origin, .active_sync_word, .dual_sync_search,
		.forward_error_coding_on, .packet_length, .sync_quality_threshold,
		.preamble_quality_threshold, .sync_quality_check_on, .postamble_length,
		.rx_timeout_stop, .tx_sequence_count, .fifo_threshold_pin,
		.duty_cycle_timer_multiplier, .low_duty_cycle_on,
		.duty_cycle_timer_reload_on, .piggyback_enable, .rx_sniff_timer_on,
		.backoff_seed_reload, .listen_before_talk_enable,
		.persistent_access_no_backoff, .auto_packet_filtering,
		.max_retransmit_count);
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (backoff_seed_reload === 1'b1) seed_seen++;
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			n_mismatch++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic tick(inout int n);
		@(posedge sys_clk);
		n++;
		if (n > 100) begin
			n_mismatch++;
			$display("Error at %0t: bus answer timed out", $time);
			complete_run();
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] strb, input logic [1:0] resp);
		int n;
		logic aw, w;
		n = 0;
		aw = 1'b1;
		w = 1'b1;
		// a is the register offset; its byte address is four times that
		s_axi_awaddr <= {a[5:0], 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw || w) begin
			tick(n);
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		repeat (slow) @(posedge sys_clk);
		s_axi_bready <= 1'b1;
		do
			tick(n);
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, resp);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [7:0] want,
		input logic [1:0] resp);
		int n;
		n = 0;
		s_axi_araddr <= {a[5:0], 2'b00};
		s_axi_arvalid <= 1'b1;
		do
			tick(n);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		repeat (slow) @(posedge sys_clk);
		s_axi_rready <= 1'b1;
		do
			tick(n);
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, {24'h0, want});
		check(s_axi_rresp, resp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		axi_wr(a, d, 4'hf, ppcr_pkg::resp_okay);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] d);
		axi_rd(a, d, ppcr_pkg::resp_okay);
	endtask
	// synchroniser depth plus output register
	task automatic settle();
		repeat (5) @(posedge sys_clk);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < 12; i++)
			rd(8'h30 + i[7:0], defaults[i]);
		check(packet_length, 16'h0014);
		check(active_sync_word, 32'h88888888);
		check(tx_data_origin, 2'h3);
		$display("test defaults done");
		for (int s = 0; s < 4; s++) begin
			wr(8'h30, {3'h0, s[0], s[1:0], 1'b1, s[1]});
			settle();
			check(tx_data_origin, s[1:0]);
			check(whitening_enable, s[0]);
			check(forward_error_coding_on, s[1]);
			check(dual_sync_search, 1'b1);
		end
		tx_mode <= 1'b1;
		settle();
		check(dual_sync_search, 1'b0);
		$display("test packet control done");
		slow = 2;
		wr(8'h31, 8'h12);
		wr(8'h32, 8'h34);
		check(packet_length, 16'h1234);
		for (int i = 0; i < 4; i++)
			wr(8'h33 + i[7:0], 8'(8'h11 * (i + 1)));
		settle();
		check(active_sync_word, 32'h11223344);
		wr(8'h37, 8'hb5);
		check({sync_quality_threshold, preamble_quality_threshold}, 7'h5a);
		check(sync_quality_check_on, 1'b1);
		wr(8'h38, 8'ha5);
		check(postamble_length, 8'ha5);
		slow = 0;
		axi_wr(8'h38, 8'h3c, 4'h0, ppcr_pkg::resp_okay);
		rd(8'h38, 8'ha5);
		rd(8'h37, 8'hb5);
		axi_wr(8'h50, 8'hff, 4'hf, ppcr_pkg::resp_slverr);
		axi_rd(8'h50, 8'h00, ppcr_pkg::resp_slverr);
		$display("test data registers done");
		for (int k = 0; k < 3; k++) begin
			{carrier_sense, sync_quality_ok, preamble_quality_ok} <= 3'h4 >> k;
			wr(8'h39, 8'he0);
			settle();
			check(rx_timeout_stop, 1'b1);
			wr(8'h39, 8'he0 ^ (8'h80 >> k));
			settle();
			check(rx_timeout_stop, 1'b0);
		end
		tx_fifo_threshold <= 1'b1;
		wr(8'h39, 8'h00);
		settle();
		check(fifo_threshold_pin, 1'b1);
		wr(8'h39, 8'h04);
		settle();
		check(fifo_threshold_pin, 1'b0);
		for (int m = 0; m < 4; m++) begin
			wr(8'h39, m[7:0]);
			check(duty_cycle_timer_multiplier, m[1:0]);
		end
		wr(8'h39, 8'h10);
		wr(8'h3c, 8'h01);
		settle();
		check(tx_sequence_count, 2'h2);
		for (int p = 0; p < 2; p++) begin
			tx_sequence_step <= 1'b1;
			settle();
			tx_sequence_step <= 1'b0;
			settle();
		end
		check(tx_sequence_count, 2'h0);
		rd(8'h3c, 8'h00);
		$display("test protocol c done");
		for (int b = 0; b < 8; b++) begin
			wr(8'h3a, 8'h01 << b);
			settle();
			check(pb_bits & 8'hf0, 8'h01 << b & 8'hf0);
			check(pb_bits & 8'h07, 8'h01 << b & 8'h07);
		end
		check(seed_seen, 1);
		wr(8'h3b, 8'hf0);
		check(max_retransmit_count, 4'hf);
		wr(8'h3b, 8'h08);
		check(max_retransmit_count, 4'h0);
		$display("test protocol a b done");
		reset_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		check(packet_length, 16'h0014);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rd(8'h3b, 8'h08);
		$display("test second reset done");
		complete_run();
	end
endmodule // tb_top
